// *** conditional_branch_skip_unit.sv ***
// condition evaluation and next program counter for skips and branches
//
// Behaviour
// RULE1: io-bit-clear skip steps pc by 2 or 3 when bit is 0; 1/2/3 cycles
// RULE2: io-bit-set skip steps pc by 2 or 3 when bit is 1; 1/2/3 cycles
// RULE3: branch-on-flag-set jumps to pc+k+1 when selected status bit is 1
// RULE4: branch-on-flag-clear jumps to pc+k+1 when bit is 0; 1/2 cycles
// RULE5: branch-if-equal jumps only when zero flag is 1; 1/2 cycles
// RULE6: branch-if-not-equal jumps to pc+k+1 only when zero flag is 0
// RULE7: carry-set and lower both jump when carry is 1; 1/2 cycles
// RULE8: carry-clear and same-or-higher both jump when carry is 0; 1/2 cycles
// RULE9: branch-if-minus jumps when negative flag is 1; 1/2 cycles
// RULE10: branch-if-plus jumps when negative flag is 0; 1/2 cycles
// RULE11: signed greater-or-equal jumps when negative xor overflow is 0
// RULE12: half-carry-set branch jumps when half carry is 1; 1/2 cycles
// RULE13: half-carry-clear branch jumps when half carry is 0; 1/2 cycles
// RULE14: bit-copy-set branch jumps when bit-copy flag is 1, else falls through
// RULE15: bit-copy-clear branch jumps when bit-copy flag is 0; 1/2 cycles
// RULE16: overflow-clear branch jumps to pc+k+1 when overflow is 0
// RULE17: signed less-than jumps when negative xor overflow is 1
// RULE18: no flag is changed; not taken ends in 1 cycle, a taken branch in 2
`timescale 1ns/1ps
`default_nettype none

module conditional_branch_skip_unit #(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7,
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // issue port from fetch logic
  input  wire logic             req,
  input  wire logic [4:0]       op,
  input  wire logic [2:0]       bit_sel,
  input  wire logic [OFS_W-1:0] offset,
  input  wire logic [PC_W-1:0]  pc,
  input  wire logic [7:0]       status_register,
  input  wire logic [7:0]       io_data,
  input  wire logic             next_two_word,
  output logic                  ready,
  output logic                  done,
  output logic                  taken,
  output logic [PC_W-1:0]       next_pc,
  // avalon-mm slave
  input  wire logic [3:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [3:0]       byteenable,
  input  wire logic [31:0]      writedata,
  output logic [31:0]           readdata,
  output logic                  waitrequest
);

  // ==========================================================
  // state
  typedef struct packed {
    branch_skip_pkg::state_t st;
    logic [1:0]              cnt;
    logic                    ready;
    logic                    done;
    logic                    taken;
    logic [PC_W-1:0]         next_pc;
    logic                    enable;
    logic                    wait_n;
    logic [31:0]             rdata;
    logic [CNT_W-1:0]        exec_cnt;
    logic [CNT_W-1:0]        taken_cnt;
  } regs_t;

  regs_t r_r;
  regs_t r_nxt;

  // ==========================================================
  // condition decode
  function automatic logic cond_eval(input logic [4:0] o,
                                     input logic [7:0] s,
                                     input logic [2:0] b,
                                     input logic [7:0] io);
    logic c;
    c = 1'b0;
    case (branch_skip_pkg::op_t'(o))
      branch_skip_pkg::skip_if_io_bit_clear:       c = !io[b]; // RULE1
      branch_skip_pkg::skip_if_io_bit_set:         c = io[b]; // RULE2
      branch_skip_pkg::branch_on_flag_set:         c = s[b]; // RULE3
      branch_skip_pkg::branch_on_flag_clear:       c = !s[b]; // RULE4
      branch_skip_pkg::branch_if_equal:
        c = s[branch_skip_pkg::FLAG_Z]; // RULE5
      branch_skip_pkg::branch_if_not_equal:
        c = !s[branch_skip_pkg::FLAG_Z]; // RULE6
      branch_skip_pkg::branch_if_carry_set,
      branch_skip_pkg::branch_if_lower:
        c = s[branch_skip_pkg::FLAG_C]; // RULE7
      branch_skip_pkg::branch_if_carry_clear,
      branch_skip_pkg::branch_if_same_or_higher:
        c = !s[branch_skip_pkg::FLAG_C]; // RULE8
      branch_skip_pkg::branch_if_minus:
        c = s[branch_skip_pkg::FLAG_N]; // RULE9
      branch_skip_pkg::branch_if_plus:
        c = !s[branch_skip_pkg::FLAG_N]; // RULE10
      branch_skip_pkg::branch_if_signed_ge:
        c = !(s[branch_skip_pkg::FLAG_N] ^
              s[branch_skip_pkg::FLAG_V]); // RULE11
      branch_skip_pkg::branch_if_signed_lt:
        c = s[branch_skip_pkg::FLAG_N] ^ s[branch_skip_pkg::FLAG_V]; // RULE17
      branch_skip_pkg::branch_if_half_carry_set:
        c = s[branch_skip_pkg::FLAG_H]; // RULE12
      branch_skip_pkg::branch_if_half_carry_clear:
        c = !s[branch_skip_pkg::FLAG_H]; // RULE13
      branch_skip_pkg::branch_if_bit_copy_set:
        c = s[branch_skip_pkg::FLAG_T]; // RULE14
      branch_skip_pkg::branch_if_bit_copy_clear:
        c = !s[branch_skip_pkg::FLAG_T]; // RULE15
      branch_skip_pkg::branch_if_overflow_clear:
        c = !s[branch_skip_pkg::FLAG_V]; // RULE16
      default:                                     c = 1'b0;
    endcase
    return c;
  endfunction : cond_eval

  function automatic logic is_skip(input logic [4:0] o);
    return (o == branch_skip_pkg::skip_if_io_bit_clear) ||
           (o == branch_skip_pkg::skip_if_io_bit_set);
  endfunction : is_skip

  // ==========================================================
  // next state
  logic            acc;
  logic            hit;
  logic [PC_W-1:0] br_pc;
  logic [PC_W-1:0] sk_pc;
  logic [PC_W-1:0] fall_pc;
  logic [1:0]      cyc;
  logic            bus_go;

  assign acc     = req && r_r.ready;
  assign hit     = cond_eval(op, status_register, bit_sel, io_data);
  assign br_pc   = pc + PC_W'($signed(offset)) +
                   PC_W'(branch_skip_pkg::STEP_BIAS);
  assign sk_pc   = pc + PC_W'(next_two_word ? branch_skip_pkg::STEP_SKIP2
                                            : branch_skip_pkg::STEP_SKIP1);
  assign fall_pc = pc + PC_W'(branch_skip_pkg::STEP_FALL);
  assign bus_go  = (read || write) && !r_r.wait_n;

  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    cyc        = branch_skip_pkg::CYC_FALL;
    // ---- bus side: one wait cycle, then answer
    r_nxt.wait_n = bus_go;
    if (bus_go && read) begin
      if (address == branch_skip_pkg::CTRL_OFS) begin
        r_nxt.rdata = 32'h0000_0000;
        r_nxt.rdata[branch_skip_pkg::CTRL_EN_BIT] = r_r.enable;
      end else if (address == branch_skip_pkg::STAT_OFS) begin
        r_nxt.rdata = 32'h0000_0000;
        r_nxt.rdata[branch_skip_pkg::STAT_BUSY_BIT]  = !r_r.ready;
        r_nxt.rdata[branch_skip_pkg::STAT_TAKEN_BIT] = r_r.taken;
        r_nxt.rdata[branch_skip_pkg::STAT_EN_BIT]    = r_r.enable;
      end else if (address == branch_skip_pkg::EXEC_OFS) begin
        r_nxt.rdata = 32'(r_r.exec_cnt);
      end else if (address == branch_skip_pkg::TAKEN_OFS) begin
        r_nxt.rdata = 32'(r_r.taken_cnt);
      end else begin
        r_nxt.rdata = 32'h0000_0000;
      end
    end
    // write lands on the edge after the wait ends, while waitrequest is low
    if (write && r_r.wait_n && byteenable[0] &&
        address == branch_skip_pkg::CTRL_OFS) begin
      r_nxt.enable = writedata[branch_skip_pkg::CTRL_EN_BIT];
      if (writedata[branch_skip_pkg::CTRL_CLR_BIT]) begin
        r_nxt.exec_cnt  = '0;
        r_nxt.taken_cnt = '0;
      end
    end
    // ---- issue side
    case (r_r.st)
      branch_skip_pkg::st_idle: begin
        if (acc) begin
          // only the pc is produced; there is no path to the flags
          r_nxt.taken = hit; // RULE18
          if (!hit) begin
            r_nxt.next_pc = fall_pc;
            cyc = branch_skip_pkg::CYC_FALL; // RULE18
          end else if (is_skip(op)) begin
            r_nxt.next_pc = sk_pc; // RULE1 RULE2
            cyc = next_two_word ? branch_skip_pkg::CYC_SKIP2
                                : branch_skip_pkg::CYC_SKIP1;
          end else begin
            r_nxt.next_pc = br_pc; // RULE3 RULE4
            cyc = branch_skip_pkg::CYC_BRANCH; // RULE18
          end
          // counters bump after a clear in the same cycle
          r_nxt.exec_cnt  = r_nxt.exec_cnt + CNT_W'(1);
          r_nxt.taken_cnt = r_nxt.taken_cnt + CNT_W'(hit);
          if (cyc == branch_skip_pkg::CYC_FALL) begin
            r_nxt.done = 1'b1;
          end else begin
            r_nxt.st  = branch_skip_pkg::st_wait;
            r_nxt.cnt = cyc - 2'h1;
          end
        end
      end
      branch_skip_pkg::st_wait: begin
        r_nxt.cnt = r_r.cnt - 2'h1;
        if (r_r.cnt == 2'h1) begin
          r_nxt.done = 1'b1;
          r_nxt.st   = branch_skip_pkg::st_idle;
        end
      end
      default: r_nxt.st = branch_skip_pkg::st_idle;
    endcase
    // a request is only seen while idle and enabled
    r_nxt.ready = r_nxt.enable && (r_nxt.st == branch_skip_pkg::st_idle);
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_r.st        <= branch_skip_pkg::st_idle;
      r_r.cnt       <= 2'h0;
      r_r.ready     <= branch_skip_pkg::CTRL_EN_RST;
      r_r.done      <= 1'b0;
      r_r.taken     <= 1'b0;
      r_r.next_pc   <= '0;
      r_r.enable    <= branch_skip_pkg::CTRL_EN_RST;
      r_r.wait_n    <= 1'b0;
      r_r.rdata     <= 32'h0000_0000;
      r_r.exec_cnt  <= '0;
      r_r.taken_cnt <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign ready       = r_r.ready;
  assign done        = r_r.done;
  assign taken       = r_r.taken;
  assign next_pc     = r_r.next_pc;
  assign readdata    = r_r.rdata;
  assign waitrequest = !r_r.wait_n;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_skip_clr_one: assert property ( // RULE1
    acc && op == branch_skip_pkg::skip_if_io_bit_clear &&
    !io_data[bit_sel] && !next_two_word |->
    ##1 !done ##1 done && taken &&
    next_pc == PC_W'($past(pc, 2) + 2))
    else $error("skip on clear bit wrong");
  a_skip_set_two: assert property ( // RULE2
    acc && op == branch_skip_pkg::skip_if_io_bit_set &&
    io_data[bit_sel] && next_two_word |->
    ##1 !done [*2] ##1 done && taken &&
    next_pc == PC_W'($past(pc, 3) + 3))
    else $error("skip on set bit wrong");
  a_flag_set_br: assert property ( // RULE3
    acc && op == branch_skip_pkg::branch_on_flag_set &&
    status_register[bit_sel] |-> ##2 done && taken &&
    next_pc == $past(pc, 2) + PC_W'($signed($past(offset, 2))) +
               PC_W'(1))
    else $error("flag set branch wrong");
  a_flag_clr_fall: assert property ( // RULE4
    acc && op == branch_skip_pkg::branch_on_flag_clear &&
    status_register[bit_sel] |=> done && !taken &&
    next_pc == $past(pc) + PC_W'(1))
    else $error("flag clear fall through wrong");
  a_equal_cond: assert property ( // RULE5
    acc && op == branch_skip_pkg::branch_if_equal |=>
    taken == $past(status_register[branch_skip_pkg::FLAG_Z]))
    else $error("equal branch condition wrong");
  a_noteq_cond: assert property ( // RULE6
    acc && op == branch_skip_pkg::branch_if_not_equal |=>
    taken != $past(status_register[branch_skip_pkg::FLAG_Z]))
    else $error("not equal branch condition wrong");
  a_lower_cond: assert property ( // RULE7
    acc && op == branch_skip_pkg::branch_if_lower |=>
    taken == $past(status_register[branch_skip_pkg::FLAG_C]))
    else $error("lower branch condition wrong");
  a_signed_ge: assert property ( // RULE11
    acc && op == branch_skip_pkg::branch_if_signed_ge |=>
    taken == !($past(status_register[branch_skip_pkg::FLAG_N]) ^
               $past(status_register[branch_skip_pkg::FLAG_V])))
    else $error("signed ge condition wrong");
  a_signed_lt: assert property ( // RULE17
    acc && op == branch_skip_pkg::branch_if_signed_lt |=>
    taken == ($past(status_register[branch_skip_pkg::FLAG_N]) ^
              $past(status_register[branch_skip_pkg::FLAG_V])))
    else $error("signed lt condition wrong");
  // ready at the end follows enable, which may drop mid-operation
  a_branch_timing: assert property ( // RULE18
    acc && !is_skip(op) && hit |=>
    !done && !ready ##1 done && ready == r_r.enable)
    else $error("taken branch not two cycles");

  c_skip_three: cover property (acc && is_skip(op) && hit && next_two_word
    ##3 done);
  c_branch_taken: cover property (acc && !is_skip(op) && hit ##2 done);
  c_bus_write: cover property (write && !waitrequest);
  c_fall: cover property (acc && !hit ##1 done && !taken);

endmodule : conditional_branch_skip_unit

`default_nettype wire

// *** branch_skip_pkg.sv ***
// constants and types shared by the conditional branch and skip unit
`default_nettype none
package branch_skip_pkg;

  // ==========================================================
  // register map, byte offsets on the bus
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STAT_OFS   = 4'h4;
  localparam logic [3:0] EXEC_OFS   = 4'h8;
  localparam logic [3:0] TAKEN_OFS  = 4'hC;

  // control and status fields
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_CLR_BIT   = 1;
  localparam logic       CTRL_EN_RST    = 1'b1;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_TAKEN_BIT = 1;
  localparam int         STAT_EN_BIT    = 2;

  // ==========================================================
  // status register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ==========================================================
  // cycle counts and program counter steps
  localparam logic [1:0] CYC_FALL   = 2'h1;
  localparam logic [1:0] CYC_BRANCH = 2'h2;
  localparam logic [1:0] CYC_SKIP1  = 2'h2;
  localparam logic [1:0] CYC_SKIP2  = 2'h3;
  localparam int         STEP_FALL  = 1;
  localparam int         STEP_SKIP1 = 2;
  localparam int         STEP_SKIP2 = 3;
  localparam int         STEP_BIAS  = 1;

  // ==========================================================
  // operation codes on the issue port
  typedef enum logic [4:0] {
    skip_if_io_bit_clear,
    skip_if_io_bit_set,
    branch_on_flag_set,
    branch_on_flag_clear,
    branch_if_equal,
    branch_if_not_equal,
    branch_if_carry_set,
    branch_if_carry_clear,
    branch_if_same_or_higher,
    branch_if_lower,
    branch_if_minus,
    branch_if_plus,
    branch_if_signed_ge,
    branch_if_signed_lt,
    branch_if_half_carry_set,
    branch_if_half_carry_clear,
    branch_if_bit_copy_set,
    branch_if_bit_copy_clear,
    branch_if_overflow_clear
  } op_t;

  typedef enum logic {
    st_idle,
    st_wait
  } state_t;

endpackage : branch_skip_pkg
`default_nettype wire

// *** fetch_model.sv ***
// fetch side model that issues skips and branches and collects results
`timescale 1ns/1ps
`default_nettype none

module fetch_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [47:0] cmd,
  input  wire logic        ready,
  input  wire logic        done,
  input  wire logic        taken,
  input  wire logic [15:0] next_pc,
  output logic             req,
  output logic [47:0]      fld,
  output logic             fin,
  output logic [3:0]       lat,
  output logic [16:0]      got
);
  // ==========================================================
  // request held until accepted, then result awaited
  logic busy;

  always @(posedge core_clk) begin
    fin <= 1'b0;
    if (sys_rst) begin
      req  <= 1'b0;
      busy <= 1'b0;
      fld  <= '0;
    end else if (req && ready) begin
      req  <= 1'b0;
      busy <= 1'b1;
      // the accept edge opens cycle one of the operation
      lat  <= 4'h1;
      // operands go stale once taken, so a late sample shows up
      fld  <= ~fld;
    end else if (busy) begin
      if (done) begin
        busy <= 1'b0;
        fin  <= 1'b1;
        got  <= {taken, next_pc};
      end else begin
        lat <= lat + 4'h1;
      end
    end else if (start) begin
      req <= 1'b1;
      fld <= cmd;
    end
  end
endmodule : fetch_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the conditional branch and skip unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ==========================================================
  // signals
  logic        core_clk = 1'b0;
  logic        sys_rst, start, read, write;
  logic        req, fin, ready, done, taken, waitrequest;
  logic [47:0] cmd, fld, rc;
  logic [3:0]  lat, address;
  logic [16:0] got;
  logic [15:0] next_pc;
  logic [31:0] writedata, readdata, rd, seed;
  int          bad_count, cmp_count, n_ops, n_tk;

  always #50 core_clk = ~core_clk;

  fetch_model fm (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
    .cmd(cmd), .ready(ready), .done(done), .taken(taken),
    .next_pc(next_pc), .req(req), .fld(fld), .fin(fin), .lat(lat),
    .got(got));

  conditional_branch_skip_unit dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .req(req), .op(fld[47:43]), .bit_sel(fld[42:40]),
    .offset(fld[39:33]), .pc(fld[32:17]), .status_register(fld[16:9]),
    .io_data(fld[8:1]), .next_two_word(fld[0]), .ready(ready),
    .done(done), .taken(taken), .next_pc(next_pc), .address(address),
    .read(read), .write(write), .byteenable(4'hF),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // result as {cycles, taken, next_pc}
  function automatic logic [20:0] expect_op(input logic [47:0] c);
    logic [2:0]  b;
    logic [15:0] pc;
    logic [7:0]  s, io;
    logic        t;
    b  = c[42:40];
    pc = c[32:17];
    s  = c[16:9];
    io = c[8:1];
    case (c[47:43])
      5'h00: t = !io[b];
      5'h01: t = io[b];
      5'h02: t = s[b];
      5'h03: t = !s[b];
      5'h04: t = s[1];
      5'h05: t = !s[1];
      5'h06, 5'h09: t = s[0];
      5'h07, 5'h08: t = !s[0];
      5'h0A: t = s[2];
      5'h0B: t = !s[2];
      5'h0C: t = !(s[2] ^ s[3]);
      5'h0D: t = s[2] ^ s[3];
      5'h0E: t = s[5];
      5'h0F: t = !s[5];
      5'h10: t = s[6];
      5'h11: t = !s[6];
      5'h12: t = !s[3];
      default: t = 1'b0;
    endcase
    if (!t) return {4'h1, 1'b0, pc + 16'h1};
    if (c[47:43] < 5'h02) begin
      return c[0] ? {4'h3, 1'b1, pc + 16'h3} : {4'h2, 1'b1, pc + 16'h2};
    end
    return {4'h2, 1'b1, pc + {{9{c[39]}}, c[39:33]} + 16'h1};
  endfunction : expect_op

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one avalon transfer, entered right after a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    address   <= a;
    writedata <= wd;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic issue(input logic [47:0] c);
    cmd   <= c;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
  endtask : issue

  task automatic finish(input logic [20:0] e);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (fin !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
    check("taken_pc", {15'h0, got}, {15'h0, e[16:0]});
    check("cycles", {28'h0, lat}, {28'h0, e[20:17]});
    n_ops++;
    n_tk += int'(e[16]);
  endtask : finish

  task automatic run_op(input logic [47:0] c);
    issue(c);
    finish(expect_op(c));
  endtask : run_op

  // both polarities, offset extremes, pc wrap, both skip lengths
  task automatic sweep(input logic [4:0] o);
    logic [1:0] i;
    for (int j = 0; j < 4; j++) begin
      i = 2'(j);
      run_op({o, 3'(j * 5), i[1] ? 7'h40 : 7'h3F, 16'hFFFE,
              {8{i[0]}} ^ {5'h0, i[1], 2'h0}, {8{i[0]}}, i[1]});
    end
  endtask : sweep

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    cmd = 48'h0;
    seed = 32'h04B2;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check("ready_rst", {31'h0, ready}, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_rst", rd, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    check("stat_rst", rd, 32'h4);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    sweep(5'h00);
    sweep(5'h01);
    sweep(5'h02);
    sweep(5'h03);
    sweep(5'h04);
    sweep(5'h05);
    sweep(5'h06);
    sweep(5'h09);
    sweep(5'h07);
    sweep(5'h08);
    sweep(5'h0A);
    sweep(5'h0B);
    sweep(5'h0C);
    sweep(5'h0E);
    sweep(5'h0F);
    sweep(5'h10);
    sweep(5'h11);
    sweep(5'h12);
    sweep(5'h0D);
    run_op({5'h1F, 43'h0});
    bus(1'b0, 4'h8, 32'h0);
    check("exec_cnt", rd, 32'(n_ops));
    bus(1'b1, 4'h8, 32'hFFFF);
    bus(1'b0, 4'h8, 32'h0);
    check("exec_ro", rd, 32'(n_ops));
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b0, 4'h8, 32'h0);
    check("exec_clr", rd, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_clr", rd, 32'h1);
    n_ops = 0;
    n_tk = 0;
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      rc[47:16] = seed;
      seed = lfsr(seed);
      rc[15:0] = seed[15:0];
      rc[47:43] = 5'(int'(rc[47:43]) % 19);
      run_op(rc);
    end
    // request held while disabled must wait, then complete
    bus(1'b1, 4'h0, 32'h0);
    issue({5'h05, 43'h0});
    repeat (4) @(posedge core_clk);
    check("ready_off", {31'h0, ready}, 32'h0);
    check("req_held", {31'h0, req}, 32'h1);
    bus(1'b1, 4'h0, 32'h1);
    finish(expect_op({5'h05, 43'h0}));
    bus(1'b0, 4'h8, 32'h0);
    check("exec_cnt", rd, 32'(n_ops));
    bus(1'b0, 4'hC, 32'h0);
    check("taken_cnt", rd, 32'(n_tk));
    bus(1'b0, 4'h4, 32'h0);
    check("stat_taken", rd, 32'h6);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
